// file: hdl/rsw_pkg.sv
// constants and types of the reset source and watchdog block
package rsw_pkg;
  // register indexes, byte address is four times the index
  localparam logic [7:0] RSW_IDX_DOG = 8'hff;
  localparam logic [7:0] RSW_IDX_SRC = 8'hef;
  localparam logic [11:0] RSW_ADDR_DOG = {2'h0, RSW_IDX_DOG, 2'h0};
  localparam logic [11:0] RSW_ADDR_SRC = {2'h0, RSW_IDX_SRC, 2'h0};
  // reset source register bits
  localparam int RSW_SRC_PIN = 0;
  localparam int RSW_SRC_POR = 1;
  localparam int RSW_SRC_CLK = 2;
  localparam int RSW_SRC_DOG = 3;
  localparam int RSW_SRC_SW = 4;
  localparam int RSW_SRC_CMP = 5;
  localparam int RSW_SRC_CNV = 6;
  localparam logic [6:0] RSW_CAUSE_RST = 7'h02;
  // watchdog control codes and fields
  localparam logic [7:0] RSW_DOG_ENABLE = 8'ha5;
  localparam logic [7:0] RSW_DOG_DIS1 = 8'hde;
  localparam logic [7:0] RSW_DOG_DIS2 = 8'had;
  localparam logic [7:0] RSW_DOG_LOCK = 8'hff;
  localparam int RSW_DOG_KEY_BIT = 7;
  localparam int RSW_DOG_ACT_BIT = 4;
  localparam logic [2:0] RSW_DOG_INT_RST = 3'h7;
  localparam logic [2:0] RSW_DOG_WIN = 3'h4;
  localparam int RSW_DOG_EXP_OFS = 3;
  localparam int RSW_DOG_W = 21;
  // timing at 50 MHz
  localparam int RSW_CLK_KHZ = 50000;
  localparam int RSW_POR_TIME_MS = 100;
  localparam int RSW_POR_CYC = RSW_POR_TIME_MS * RSW_CLK_KHZ;
  localparam logic [22:0] RSW_PIN_HOLD_CYC = 23'd12;
  // values presented to the rest of the chip
  localparam logic [7:0] RSW_PORT_LATCH_RST = 8'hff;
  localparam logic [15:0] RSW_RESET_VECTOR = 16'h0000;
  typedef enum logic [1:0] {RSW_RUN, RSW_HOLD, RSW_STRETCH} rsw_state_t;
endpackage

// file: hdl/rsw_sync.sv
// two flip-flop synchroniser for pin level inputs
`timescale 1ns/1ns
module rsw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule

// file: hdl/rsw_dog.sv
// watchdog timer with unlock, lockout and interval
`timescale 1ns/1ns
module rsw_dog
  import rsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_rst,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic active,
  output logic [2:0] interval,
  output logic overflow
);
  logic en_q, en_d;
  logic lock_q, lock_d;
  logic pend_q, pend_d;
  logic [2:0] win_q, win_d;
  logic [2:0] int_q, int_d;
  logic [RSW_DOG_W-1:0] cnt_q, cnt_d;
  logic [RSW_DOG_W-1:0] limit;

  // 4^(3+n) = 2^(6+2n) cycles
  always_comb begin
    limit = '0;
    limit[2 * (RSW_DOG_EXP_OFS + 32'(int_q))] = 1'b1;
  end

  always_comb begin
    en_d = en_q;
    lock_d = lock_q;
    pend_d = pend_q;
    win_d = win_q;
    int_d = int_q;
    cnt_d = cnt_q;
    overflow = 1'b0;
    if (sys_rst) begin
      en_d = 1'b1;
      cnt_d = '0;
      lock_d = 1'b0;
      pend_d = 1'b0;
      win_d = '0;
      int_d = RSW_DOG_INT_RST;
    end else begin
      if (en_q) begin
        if (cnt_q >= limit - RSW_DOG_W'(1)) begin
          overflow = 1'b1;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + RSW_DOG_W'(1);
        end
      end
      if (pend_q) begin
        win_d = win_q + 3'h1;
        if (win_q == RSW_DOG_WIN - 3'h1) begin
          pend_d = 1'b0;
        end
      end
      if (wr) begin
        pend_d = 1'b0;
        if (!wdata[RSW_DOG_KEY_BIT]) begin
          int_d = wdata[2:0];
        end
        if (wdata == RSW_DOG_ENABLE) begin
          en_d = 1'b1;
          cnt_d = '0;
        end else if (wdata == RSW_DOG_DIS1) begin
          pend_d = 1'b1;
          win_d = '0;
        end else if (wdata == RSW_DOG_DIS2 && pend_q && win_q < RSW_DOG_WIN && !lock_q) begin
          en_d = 1'b0;
        end else if (wdata == RSW_DOG_LOCK) begin
          lock_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b1;
      lock_q <= 1'b0;
      pend_q <= 1'b0;
      win_q <= '0;
      int_q <= RSW_DOG_INT_RST;
      cnt_q <= '0;
    end else begin
      en_q <= en_d;
      lock_q <= lock_d;
      pend_q <= pend_d;
      win_q <= win_d;
      int_q <= int_d;
      cnt_q <= cnt_d;
    end
  end

  assign active = en_q;
  assign interval = int_q;
endmodule

// file: hdl/rsw_ctrl.sv
// reset source controller with apb registers and watchdog
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ns
module rsw_ctrl
  import rsw_pkg::*;
#(
  parameter int POR_CYCLES = RSW_POR_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_low,
  input wire logic supply_monitor_enable_pin,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  input wire logic convert_start_input,
  input wire logic cmp_out,
  input wire logic clock_missing,
  input wire logic clock_stable,
  output logic clock_loss_enable,
  output logic adc_convert_start_n,
  output logic sys_rst,
  output logic clock_default_sel,
  output logic [7:0] port_latch_init,
  output logic [15:0] reset_vector
);
  localparam logic [22:0] POR_LOAD = 23'(POR_CYCLES - 1);

  rsw_state_t state_q, state_d;
  logic [22:0] cnt_q, cnt_d;
  logic [6:0] cause_q, cause_d;
  logic drive_q, drive_d;
  logic [2:0] drive_hist_q, drive_hist_d;
  logic supply_sel_q, supply_sel_d;
  logic clk_en_q, clk_en_d;
  logic cmp_en_q, cmp_en_d;
  logic cnv_en_q, cnv_en_d;
  logic cnv_pass_q, cnv_pass_d;
  logic [31:0] rdata_q, rdata_d;

  logic supply_low_s, mon_en_s, pin_s, cnv_s, cmp_s, clk_miss_s, clk_stable_s;
  logic setup, access, wr_acc;
  logic sel_dog, sel_src;
  logic dog_active, dog_ovf;
  logic [2:0] dog_int;
  logic src_supply, src_pin, src_clk, src_cmp, src_cnv;
  logic force_por, force_sw, level_any, por_class;
  logic [6:0] new_cause;

  // pin level inputs: idle values chosen as not-in-reset, except clock_stable which starts low and holds reset
  rsw_sync #(.W(7), .RST_VAL(7'h1c)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({supply_low, supply_monitor_enable_pin, rst_pin_i, convert_start_input, cmp_out,
        clock_missing, clock_stable}),
    .q({supply_low_s, mon_en_s, pin_s, cnv_s, cmp_s, clk_miss_s, clk_stable_s})
  );

  // address decode, used for reads and writes
  function automatic logic [1:0] decode(input logic [11:0] a);
    if (a == RSW_ADDR_DOG) begin
      decode = 2'h1;
    end else if (a == RSW_ADDR_SRC) begin
      decode = 2'h2;
    end else begin
      decode = 2'h0;
    end
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign sel_dog = decode(paddr) == 2'h1;
  assign sel_src = decode(paddr) == 2'h2;
  assign wr_acc = access && pwrite && state_q == RSW_RUN;
  assign pready = 1'b1;
  assign pslverr = access && decode(paddr) == 2'h0;
  assign prdata = rdata_q;

  rsw_dog u_dog (
    .pclk(pclk),
    .presetn(presetn),
    .sys_rst(sys_rst),
    .wr(wr_acc && sel_dog),
    .wdata(pwdata[7:0]),
    .active(dog_active),
    .interval(dog_int),
    .overflow(dog_ovf)
  );

  // read data captured in the setup cycle
  always_comb begin
    rdata_d = rdata_q;
    if (setup) begin
      rdata_d = '0;
      if (sel_dog) begin
        rdata_d[RSW_DOG_ACT_BIT] = dog_active;
        rdata_d[2:0] = dog_int;
      end else if (sel_src) begin
        rdata_d[6:0] = cause_q;
      end
    end
  end

  // reset requests
  always_comb begin
    src_supply = mon_en_s && supply_sel_q && supply_low_s;
    // own drive of the pin reads back low; ignore it until it has settled
    src_pin = !pin_s && !drive_q && drive_hist_q == 3'h0;
    src_clk = clk_en_q && clk_miss_s;
    src_cmp = cmp_en_q && !cmp_s;
    src_cnv = cnv_en_q && !cnv_s;
    force_por = wr_acc && sel_src && pwdata[RSW_SRC_PIN];
    force_sw = wr_acc && sel_src && pwdata[RSW_SRC_SW];
    level_any = src_supply || src_pin || src_clk || src_cmp || src_cnv;
    por_class = src_supply || force_por;
    new_cause = '0;
    if (por_class) begin
      new_cause[RSW_SRC_POR] = 1'b1;
    end else if (src_pin) begin
      new_cause[RSW_SRC_PIN] = 1'b1;
    end else if (src_clk) begin
      new_cause[RSW_SRC_CLK] = 1'b1;
    end else if (src_cmp) begin
      new_cause[RSW_SRC_CMP] = 1'b1;
    end else if (src_cnv) begin
      new_cause[RSW_SRC_CNV] = 1'b1;
    end else if (force_sw) begin
      new_cause[RSW_SRC_SW] = 1'b1;
    end else if (dog_ovf) begin
      new_cause[RSW_SRC_DOG] = 1'b1;
    end
  end

  // reset sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cause_d = cause_q;
    drive_d = drive_q;
    supply_sel_d = supply_sel_q;
    clk_en_d = clk_en_q;
    cmp_en_d = cmp_en_q;
    cnv_en_d = cnv_en_q;
    case (state_q)
      RSW_RUN: begin
        if (new_cause != 7'h00) begin
          state_d = RSW_HOLD;
          cause_d = new_cause;
          drive_d = por_class;
        end else if (wr_acc && sel_src) begin
          supply_sel_d = pwdata[RSW_SRC_POR];
          clk_en_d = pwdata[RSW_SRC_CLK];
          cmp_en_d = pwdata[RSW_SRC_CMP];
          cnv_en_d = pwdata[RSW_SRC_CNV];
        end
      end
      RSW_HOLD: begin
        if (src_supply) begin
          cause_d = 7'h00;
          cause_d[RSW_SRC_POR] = 1'b1;
          drive_d = 1'b1;
        end else if (!level_any) begin
          state_d = RSW_STRETCH;
          cnt_d = drive_q ? POR_LOAD : RSW_PIN_HOLD_CYC - 23'd1;
        end
      end
      default: begin
        if (level_any) begin
          state_d = RSW_HOLD;
          if (src_supply) begin
            cause_d = 7'h00;
            cause_d[RSW_SRC_POR] = 1'b1;
            drive_d = 1'b1;
          end
        end else if (cnt_q != 23'd0) begin
          cnt_d = cnt_q - 23'd1;
        end else if (clk_stable_s) begin
          state_d = RSW_RUN;
          drive_d = 1'b0;
          supply_sel_d = 1'b1;
          clk_en_d = 1'b0;
          cmp_en_d = 1'b0;
          cnv_en_d = 1'b0;
        end
      end
    endcase
  end

  // pin echo history and conversion start gating
  always_comb begin
    drive_hist_d = {drive_hist_q[1:0], drive_q};
    cnv_pass_d = cnv_en_q ? 1'b1 : cnv_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RSW_STRETCH;
      cnt_q <= POR_LOAD;
      cause_q <= RSW_CAUSE_RST;
      drive_q <= 1'b1;
      drive_hist_q <= 3'h7;
      supply_sel_q <= 1'b1;
      clk_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
      cnv_en_q <= 1'b0;
      cnv_pass_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cause_q <= cause_d;
      drive_q <= drive_d;
      drive_hist_q <= drive_hist_d;
      supply_sel_q <= supply_sel_d;
      clk_en_q <= clk_en_d;
      cmp_en_q <= cmp_en_d;
      cnv_en_q <= cnv_en_d;
      cnv_pass_q <= cnv_pass_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs to the rest of the chip
  assign sys_rst = state_q != RSW_RUN;
  assign clock_default_sel = sys_rst;
  assign port_latch_init = RSW_PORT_LATCH_RST;
  assign reset_vector = RSW_RESET_VECTOR;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = drive_q;
  assign clock_loss_enable = clk_en_q;
  assign adc_convert_start_n = cnv_pass_q;
endmodule

// file: verif/rsw_ctrl_asserts.sv
// checker for the reset source and watchdog block
`timescale 1ns/1ns
module rsw_ctrl_asserts
  import rsw_pkg::*;
#(
  parameter int POR_CYCLES = RSW_POR_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rst_pin_i,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  input wire logic sys_rst,
  input wire logic clock_default_sel,
  input wire logic [7:0] port_latch_init,
  input wire logic [15:0] reset_vector
);
  logic wsrc;
  assign wsrc = psel && penable && pwrite && paddr == RSW_ADDR_SRC && !sys_rst;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pin_low_only: assert property (rst_pin_oe |-> !rst_pin_o && sys_rst)
    else $error("reset pin driven high");
  a_latch_ones: assert property (port_latch_init == 8'hff)
    else $error("port latch init not all ones");
  a_vector_zero: assert property (reset_vector == 16'h0000)
    else $error("reset vector not zero");
  a_clock_default: assert property (clock_default_sel == sys_rst)
    else $error("clock default select differs from reset");
  a_pin_enters: assert property (!rst_pin_i && !rst_pin_oe && !sys_rst |-> ##[1:5] sys_rst)
    else $error("pin low did not reset");
  a_stretch_min: assert property ($fell(sys_rst) |-> $past(sys_rst, 12))
    else $error("reset shorter than twelve cycles");
  a_soft_reset: assert property (wsrc && pwdata[4] |-> ##[1:3] sys_rst)
    else $error("soft reset write ignored");
  a_por_write: assert property (wsrc && pwdata[0] |-> ##[1:3] rst_pin_oe)
    else $error("pin flag write did not drive pin");
  a_oe_release: assert property ($fell(rst_pin_oe) |-> $fell(sys_rst))
    else $error("pin released after reset ended");
endmodule
bind rsw_ctrl rsw_ctrl_asserts #(.POR_CYCLES(POR_CYCLES)) rsw_ctrl_asserts_inst (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .rst_pin_i, .rst_pin_o,
  .rst_pin_oe, .sys_rst, .clock_default_sel, .port_latch_init, .reset_vector);

// file: verif/rsw_pin_model.sv
// reset pin on the board, pull-up plus external low request
`timescale 1ns/1ns
module rsw_pin_model (
  input wire logic ext_low,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  output logic rst_pin_i
);
  assign rst_pin_i = rst_pin_oe ? rst_pin_o : !ext_low;
endmodule

// file: verif/rsw_ctrl_bench.sv
// bench for the reset source and watchdog block
`timescale 1ns/1ns
module rsw_ctrl_bench
  import rsw_pkg::*;
;
  localparam int PC = 50;
  localparam logic [11:0] AS = RSW_ADDR_SRC;
  localparam logic [11:0] AD = RSW_ADDR_DOG;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rst_pin_i, rst_pin_o, rst_pin_oe, clock_loss_enable;
  logic adc_convert_start_n, sys_rst, clock_default_sel;
  logic [7:0] port_latch_init;
  logic [15:0] reset_vector;
  logic supply_low = 0, ext_low = 0, cnv_in = 1, cmp_out = 1, clock_missing = 0;
  logic mon_en = 1, clk_ok = 1;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  logic oe;
  always #10 pclk = !pclk;
  rsw_ctrl #(.POR_CYCLES(PC)) rsw_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_low,
    .supply_monitor_enable_pin(mon_en), .rst_pin_i, .rst_pin_o, .rst_pin_oe,
    .convert_start_input(cnv_in), .cmp_out, .clock_missing, .clock_stable(clk_ok),
    .clock_loss_enable, .adc_convert_start_n, .sys_rst, .clock_default_sel,
    .port_latch_init, .reset_vector);
  rsw_pin_model rsw_pin_model_inst (.ext_low, .rst_pin_o, .rst_pin_oe, .rst_pin_i);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
      input logic [31:0] x);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) chk(32'(pready), 1);
    err = pslverr;
    if (!w) chk(prdata, x);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic settle;
    oe = 0;
    n = 0;
    while (sys_rst !== 1'b1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(sys_rst), 1);
    n = 0;
    while (sys_rst === 1'b1 && n < 500) begin
      oe = oe | (rst_pin_oe === 1'b1);
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(sys_rst), 0);
  endtask
  task automatic t_boot;
    settle();
    chk(32'(oe && n >= PC), 1);
    acc(0, AS, 0, 32'h02);
    acc(0, AD, 0, 32'h17);
    acc(0, 12'h100, 0, 0);
    chk(32'(err), 1);
  endtask
  task automatic t_dog;
    acc(1, AD, 8'h00, 0);
    acc(0, AD, 0, 32'h10);
    acc(1, AD, 8'ha5, 0);
    repeat (40) @(posedge pclk);
    acc(1, AD, 8'ha5, 0);
    n = 0;
    while (sys_rst !== 1'b1 && n < 200) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(n >= 62 && n <= 68), 1);
    settle();
    chk(32'(oe), 0);
    acc(0, AS, 0, 32'h08);
    acc(0, AD, 0, 32'h17);
  endtask
  task automatic t_dis;
    acc(1, AD, 8'hde, 0);
    acc(1, AD, 8'had, 0);
    acc(0, AD, 0, 32'h07);
    acc(1, AD, 8'ha5, 0);
    acc(1, AD, 8'hde, 0);
    repeat (2) @(posedge pclk);
    acc(1, AD, 8'had, 0);
    acc(0, AD, 0, 32'h17);
    acc(1, AD, 8'hff, 0);
    acc(1, AD, 8'hde, 0);
    acc(1, AD, 8'had, 0);
    acc(0, AD, 0, 32'h17);
  endtask
  task automatic t_soft;
    acc(1, AS, 8'h12, 0);
    settle();
    chk(32'(oe), 0);
    acc(0, AS, 0, 32'h10);
    acc(1, AD, 8'hde, 0);
    acc(1, AD, 8'had, 0);
    acc(0, AD, 0, 32'h07);
    acc(1, AD, 8'ha5, 0);
  endtask
  task automatic t_stable;
    clk_ok <= 0;
    acc(1, AS, 8'h12, 0);
    repeat (40) @(posedge pclk);
    chk(32'(sys_rst), 1);
    clk_ok <= 1;
    settle();
    chk(32'(n >= 2 && n <= 4), 1);
    acc(0, AS, 0, 32'h10);
  endtask
  task automatic t_pin;
    ext_low <= 1;
    repeat (5) @(posedge pclk);
    ext_low <= 0;
    settle();
    chk(32'(!oe && n >= 12), 1);
    acc(0, AS, 0, 32'h01);
  endtask
  task automatic t_level;
    logic [7:0] en [3] = '{8'h06, 8'h22, 8'h42};
    for (int i = 0; i < 3; i++) begin
      acc(1, AS, en[i], 0);
      clock_missing <= (i == 0);
      cmp_out <= (i != 1);
      cnv_in <= (i != 2);
      repeat (6) @(posedge pclk);
      if (i == 0) chk(32'(clock_loss_enable), 1);
      if (i == 2) chk(32'(adc_convert_start_n), 1);
      clock_missing <= 0;
      cmp_out <= 1;
      cnv_in <= 1;
      settle();
      chk(32'(oe), 0);
      acc(0, AS, 0, 32'(en[i] & 8'h74));
    end
  endtask
  task automatic t_supply;
    acc(1, AS, 8'h03, 0);
    settle();
    chk(32'(oe && n >= PC), 1);
    acc(0, AS, 0, 32'h02);
    supply_low <= 1;
    repeat (5) @(posedge pclk);
    supply_low <= 0;
    settle();
    chk(32'(oe && n >= PC), 1);
    acc(0, AS, 0, 32'h02);
    mon_en <= 0;
    supply_low <= 1;
    repeat (6) @(posedge pclk);
    chk(32'(sys_rst), 0);
    supply_low <= 0;
    repeat (2) @(posedge pclk);
    mon_en <= 1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_boot();
    t_dog();
    t_dis();
    t_soft();
    t_stable();
    t_pin();
    t_level();
    t_supply();
    summarize();
  end
  initial begin
    #400000;
    bad_count++;
    $display("unexpected at %0t: run hung", $time);
    summarize();
  end
endmodule
